// >>> svrg_core.v
// Space vector reference generator: per-period angle stepping, sine
// lookup, duty decomposition, loop gating, button poll and speed gating.
// Assumes period_event is a one-cycle pulse from the PWM timer, buttons
// and capture_event are synchronous to pclk, and an APB master drives the bus.
`timescale 1ns/1ps
`include "svrg_map.vh"
module svrg_core #(
  parameter STARTUP_TICKS = `SVRG_STARTUP_TICKS,
  parameter TABLE_DEPTH = 256
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Period tick and operator inputs
  input wire period_event,
  input wire speed_up_button,
  input wire speed_down_button,
  input wire capture_event,
  // Results towards the compare units
  output reg [`SVRG_DUTY_W-1:0] duty_x,
  output reg [`SVRG_DUTY_W-1:0] duty_y,
  output reg [`SVRG_DUTY_W:0] duty_z,
  output reg [2:0] sector,
  output reg duty_valid,
  // Loop and speed gating
  output reg closed_loop_enable_flag,
  output reg regulate_strobe,
  output reg speed_update_strobe,
  output reg [`SVRG_STEP_W-1:0] freq_setpoint
);

  // ============================================================
  // State encoding of the per-period sequence
  localparam ST_IDLE = 5'b00001;
  localparam ST_ADV = 5'b00010;
  localparam ST_FETCH = 5'b00100;
  localparam ST_MULT = 5'b01000;
  localparam ST_STORE = 5'b10000;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [`SVRG_ACC_W-1:0] angle_acc_r;
  reg [`SVRG_IDX_W-1:0] table_index_r;
  reg [`SVRG_IDX_W-1:0] previous_table_index_r;
  reg [`SVRG_IDX_W-1:0] comp_index_r;
  reg signed [15:0] mod_index_r;
  reg [31:0] startup_cnt_r;
  reg capture_pending_r;
  reg restart_r;
  reg signed [31:0] prod_x_r;
  reg signed [31:0] prod_y_r;
  reg [31:0] read_nxt;
  reg [`SVRG_DUTY_W:0] duty_z_nxt;
  reg [2:0] sector_nxt;
  wire signed [15:0] sin_alpha;
  wire signed [15:0] sin_comp;
  wire [63:0] prod_pair;
  wire [2*`SVRG_DUTY_W-1:0] cnt_pair;
  wire [`SVRG_DUTY_W-1:0] cnt_x;
  wire [`SVRG_DUTY_W-1:0] cnt_y;
  wire [`SVRG_DUTY_W:0] active_sum;
  wire [`SVRG_ACC_W-1:0] angle_sum;
  wire sector_wrap;
  wire apb_setup;
  wire apb_wr;
  wire addr_hit;
  wire startup_done;
  wire step_over;
  genvar lane;

  // ============================================================
  // APB decode; zero wait states, so every access ends in one cycle
  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign addr_hit = (paddr == `SVRG_CTRL_OFS) | (paddr == `SVRG_STEP_OFS) |
                    (paddr == `SVRG_MODIDX_OFS) | (paddr == `SVRG_STATUS_OFS) |
                    (paddr == `SVRG_DUTY_OFS) | (paddr == `SVRG_SPEED_OFS);
  // Any bit above the step field counts as over the limit, never as a wrapped value
  assign step_over = (|pwdata[31:`SVRG_STEP_W]) | (pwdata[`SVRG_STEP_W-1:0] > `SVRG_STEP_MAX);

  // Read word chosen combinationally, registered only in the setup cycle
  always @* begin
    read_nxt = 32'h00000000;
    case (paddr)
      `SVRG_STEP_OFS: read_nxt = {20'h00000, freq_setpoint};
      `SVRG_MODIDX_OFS: read_nxt = {16'h0000, mod_index_r};
      `SVRG_STATUS_OFS: read_nxt = {4'h0, table_index_r, closed_loop_enable_flag, sector, angle_acc_r};
      `SVRG_DUTY_OFS: read_nxt = {1'b0, duty_z, duty_y, duty_x};
      `SVRG_SPEED_OFS: read_nxt = {31'h00000000, capture_pending_r};
      default: read_nxt = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle so it is a flip-flop in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= ~addr_hit;
      prdata <= read_nxt;
    end
  end

  // ============================================================
  // Software controls: modulation index and restart pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_index_r <= `SVRG_MODIDX_RST;
      restart_r <= 1'b0;
    end else begin
      restart_r <= apb_wr & (paddr == `SVRG_CTRL_OFS) & pwdata[`SVRG_CTRL_RESTART_BIT];
      if (apb_wr && paddr == `SVRG_MODIDX_OFS) begin
        mod_index_r <= pwdata[15:0];
      end
    end
  end

  // ============================================================
  // Frequency set point: software write wins over a button in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_setpoint <= `SVRG_STEP_RST;
    end else if (apb_wr && paddr == `SVRG_STEP_OFS) begin
      if (step_over) begin
        freq_setpoint <= `SVRG_STEP_MAX;
      end else begin
        freq_setpoint <= pwdata[`SVRG_STEP_W-1:0];
      end
    end else if (period_event) begin
      // Both pressed at once cancels out rather than favouring one
      if (speed_up_button && !speed_down_button && freq_setpoint < `SVRG_STEP_MAX) begin
        freq_setpoint <= freq_setpoint + 12'h001;
      end else if (speed_down_button && !speed_up_button && freq_setpoint != 12'h000) begin
        freq_setpoint <= freq_setpoint - 12'h001;
      end
    end
  end

  // ============================================================
  // Open-loop startup interval, then the closed-loop flag
  assign startup_done = (startup_cnt_r >= STARTUP_TICKS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_cnt_r <= 32'h00000000;
      closed_loop_enable_flag <= 1'b0;
    end else if (restart_r) begin
      startup_cnt_r <= 32'h00000000;
      closed_loop_enable_flag <= 1'b0;
    end else if (period_event) begin
      if (!startup_done) begin
        startup_cnt_r <= startup_cnt_r + 32'h00000001;
      end else begin
        closed_loop_enable_flag <= 1'b1;
      end
    end
  end

  // ============================================================
  // Regulation and speed strobes, one cycle each, only on a tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulate_strobe <= 1'b0;
      speed_update_strobe <= 1'b0;
      capture_pending_r <= 1'b0;
    end else begin
      regulate_strobe <= period_event & closed_loop_enable_flag;
      speed_update_strobe <= period_event & (capture_pending_r | capture_event);
      // A capture arriving on the consuming tick is taken by that tick, not lost
      if (capture_event) begin
        capture_pending_r <= ~period_event;
      end else if (period_event) begin
        capture_pending_r <= 1'b0;
      end
    end
  end

  // ============================================================
  // Sequence: advance, fetch sines, multiply, store duties
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (period_event) begin
          state_nxt = ST_ADV;
        end
      end
      ST_ADV: state_nxt = ST_FETCH;
      ST_FETCH: state_nxt = ST_MULT;
      ST_MULT: state_nxt = ST_STORE;
      ST_STORE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else if (restart_r) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ============================================================
  // Angle accumulator and table pointers
  assign angle_sum = angle_acc_r + {4'h0, freq_setpoint};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_acc_r <= 16'h0000;
      table_index_r <= 8'h00;
      previous_table_index_r <= 8'h00;
      comp_index_r <= `SVRG_IDX_LAST;
    end else if (restart_r) begin
      angle_acc_r <= 16'h0000;
      table_index_r <= 8'h00;
      previous_table_index_r <= 8'h00;
      comp_index_r <= `SVRG_IDX_LAST;
    end else if (state_r == ST_ADV) begin
      previous_table_index_r <= table_index_r;
      angle_acc_r <= angle_sum;
      table_index_r <= angle_sum[`SVRG_ACC_W-1:`SVRG_ACC_W-`SVRG_IDX_W];
      comp_index_r <= `SVRG_IDX_LAST - angle_sum[`SVRG_ACC_W-1:`SVRG_ACC_W-`SVRG_IDX_W];
    end
  end

  // ============================================================
  // Sine lookup: port a gives sin(a), port b the complementary angle
  svrg_sine_rom #(
    .DEPTH(TABLE_DEPTH),
    .AW(`SVRG_IDX_W)
  ) u_sine (
    .pclk(pclk),
    .addr_a(table_index_r),
    .addr_b(comp_index_r),
    .data_a(sin_alpha),
    .data_b(sin_comp)
  );

  // ============================================================
  // Products: identical for every sector, angle taken from sector start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prod_x_r <= 32'sh00000000;
      prod_y_r <= 32'sh00000000;
    end else if (state_r == ST_MULT) begin
      prod_x_r <= mod_index_r * sin_comp;
      prod_y_r <= mod_index_r * sin_alpha;
    end
  end

  // Lane 0 scales the first active duty, lane 1 the second
  assign prod_pair = {prod_y_r, prod_x_r};
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_scale
      wire [15:0] q15;
      // Shift left once to return to Q15, then keep its top ten fraction bits
      assign q15 = prod_pair[lane*32+15 +: 16];
      // Negative modulation index makes no sense here, so negatives clamp to zero
      assign cnt_pair[lane*`SVRG_DUTY_W +: `SVRG_DUTY_W] = q15[15] ? 10'h000 : q15[14:5];
    end
  endgenerate
  assign cnt_x = cnt_pair[`SVRG_DUTY_W-1:0];
  assign cnt_y = cnt_pair[2*`SVRG_DUTY_W-1:`SVRG_DUTY_W];
  assign active_sum = {1'b0, cnt_x} + {1'b0, cnt_y};

  // ============================================================
  // Sector pointer: a backward step of the index means a 60-degree crossing
  assign sector_wrap = (table_index_r < previous_table_index_r);

  // ============================================================
  // Next zero-vector time and sector, settled before the store edge
  always @* begin
    duty_z_nxt = `SVRG_FULL_PERIOD;
    sector_nxt = sector;
    // Zero vector (000 or 111) time is whatever the active vectors leave
    if (active_sum > `SVRG_FULL_PERIOD) begin
      duty_z_nxt = 11'h000;
    end else begin
      duty_z_nxt = `SVRG_FULL_PERIOD - active_sum;
    end
    if (sector_wrap) begin
      sector_nxt = (sector == `SVRG_SECTOR_LAST) ? 3'h0 : sector + 3'h1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_x <= 10'h000;
      duty_y <= 10'h000;
      duty_z <= `SVRG_FULL_PERIOD;
      sector <= 3'h0;
      duty_valid <= 1'b0;
    end else begin
      // A restart cancels the store, so no half-finished update is announced
      duty_valid <= (state_r == ST_STORE) & ~restart_r;
      if (restart_r) begin
        sector <= 3'h0;
      end else if (state_r == ST_STORE) begin
        duty_x <= cnt_x;
        duty_y <= cnt_y;
        duty_z <= duty_z_nxt;
        sector <= sector_nxt;
      end
    end
  end

endmodule

// >>> svrg_core_chk.sv
// Concurrent checks on the reference generator core ports.
// Assumes it is bound onto svrg_core; one clock, pclk, async reset presetn.
`timescale 1ns/1ps
`include "svrg_map.vh"
module svrg_core_chk #(
  parameter STARTUP_TICKS = 4
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Inputs that cause changes
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire period_event,
  input wire speed_up_button,
  input wire speed_down_button,
  // Outputs under check
  input wire [`SVRG_DUTY_W-1:0] duty_x,
  input wire [`SVRG_DUTY_W-1:0] duty_y,
  input wire [`SVRG_DUTY_W:0] duty_z,
  input wire [2:0] sector,
  input wire duty_valid,
  input wire closed_loop_enable_flag,
  input wire regulate_strobe,
  input wire speed_update_strobe,
  input wire [`SVRG_STEP_W-1:0] freq_setpoint
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ============================================================
  // Properties
  property p_fill;
    duty_valid && ({1'b0, duty_x} + duty_y <= 11'h400) |-> {1'b0, duty_x} + duty_y + duty_z == 11'h400;
  endproperty
  a_fill: assert property (p_fill) else $error("duty sum differs from full period");
  property p_lat;
    duty_valid |-> $past(period_event, 5);
  endproperty
  a_lat: assert property (p_lat) else $error("duty update without tick five cycles before");
  property p_pulse;
    duty_valid |=> !duty_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("duty valid longer than one cycle");
  property p_zfloor;
    duty_z <= `SVRG_FULL_PERIOD;
  endproperty
  a_zfloor: assert property (p_zfloor) else $error("zero duty above full period");
  property p_sec;
    sector <= `SVRG_SECTOR_LAST;
  endproperty
  a_sec: assert property (p_sec) else $error("sector out of range");
  property p_secstep;
    duty_valid && $changed(sector) |-> sector == (($past(sector) == 3'h5) ? 3'h0 : $past(sector) + 3'h1);
  endproperty
  a_secstep: assert property (p_secstep) else $error("sector skipped");
  property p_sechold;
    $changed(sector) |-> duty_valid || sector == 3'h0;
  endproperty
  a_sechold: assert property (p_sechold) else $error("sector moved between updates");
  property p_reg;
    regulate_strobe |-> $past(closed_loop_enable_flag) && $past(period_event);
  endproperty
  a_reg: assert property (p_reg) else $error("regulation step while open loop");
  property p_spd;
    speed_update_strobe |-> $past(period_event);
  endproperty
  a_spd: assert property (p_spd) else $error("speed update off tick");
  property p_btn;
    $changed(freq_setpoint) |-> $past(psel && penable && pwrite) ||
      ($past(period_event) && $past(speed_up_button != speed_down_button));
  endproperty
  a_btn: assert property (p_btn) else $error("set point moved without button");
  property p_max;
    freq_setpoint <= `SVRG_STEP_MAX;
  endproperty
  a_max: assert property (p_max) else $error("set point above step limit");
  // ============================================================
  // Coverage of main scenarios
  c_tick: cover property (duty_valid);
  c_reg: cover property (regulate_strobe);
  c_spd: cover property (speed_update_strobe);
  c_wrap: cover property (duty_valid && $changed(sector));
endmodule

// >>> svrg_core_tb.sv
// Self-checking bench for svrg_core over APB with the PWM tick model.
// Assumes a 100 ns pclk and a shortened open-loop startup count.
`timescale 1ns/1ps
`include "svrg_map.vh"
module svrg_core_tb;
  localparam STARTUP_TICKS = 4;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg speed_up_button = 1'b0;
  reg speed_down_button = 1'b0;
  reg capture_event = 1'b0;
  wire pready, pslverr, period_event, duty_valid, closed_loop_enable_flag, regulate_strobe, speed_update_strobe;
  wire [31:0] prdata;
  wire [9:0] duty_x, duty_y;
  wire [10:0] duty_z;
  wire [2:0] sector;
  wire [11:0] freq_setpoint;
  integer fail_count = 0;
  integer cmp_count = 0;
  integer reg_cnt = 0;
  integer spd_cnt = 0;
  integer base;
  reg [31:0] rd;
  reg err;
  svrg_core #(.STARTUP_TICKS(STARTUP_TICKS)) u_svrg_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .period_event(period_event), .speed_up_button(speed_up_button),
    .speed_down_button(speed_down_button), .capture_event(capture_event), .duty_x(duty_x), .duty_y(duty_y),
    .duty_z(duty_z), .sector(sector), .duty_valid(duty_valid), .closed_loop_enable_flag(closed_loop_enable_flag),
    .regulate_strobe(regulate_strobe), .speed_update_strobe(speed_update_strobe), .freq_setpoint(freq_setpoint));
  svrg_pwm_model u_svrg_pwm_model (.pclk(pclk), .presetn(presetn), .period_event(period_event));
  always #50 pclk = ~pclk;
  // Strobes are single cycles, so count them as they pass
  always @(posedge pclk) begin
    if (regulate_strobe === 1'b1) reg_cnt <= reg_cnt + 1;
    if (speed_update_strobe === 1'b1) spd_cnt <= spd_cnt + 1;
  end
  // ============================================================
  // Shared tasks
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task tick(input integer k);
    integer n;
    repeat (k) begin
      n = 0;
      @(posedge pclk);
      while (duty_valid !== 1'b1 && n < 1000) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 1000) chk("duty_valid", 32'h0, 32'h1);
    end
  endtask
  task restart;
    apb(1'b1, `SVRG_CTRL_OFS, 32'h1);
    repeat (2) @(posedge pclk);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task t_reset;
    apb(1'b0, `SVRG_STATUS_OFS, 32'h0);
    chk("status", rd, 32'h0);
    chk("mapped slverr", err, 1'b0);
    chk("pready", pready, 1'b1);
    apb(1'b0, `SVRG_DUTY_OFS, 32'h0);
    chk("duty", rd, 32'h40000000);
  endtask
  task t_regs;
    apb(1'b1, `SVRG_STEP_OFS, 32'hfff);
    apb(1'b0, `SVRG_STEP_OFS, 32'h0);
    chk("step", rd, 32'h800);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `SVRG_DUTY_OFS, 32'hffffffff);
    apb(1'b0, `SVRG_DUTY_OFS, 32'h0);
    chk("duty ro", rd, 32'h40000000);
  endtask
  task t_accum;
    restart;
    tick(1);
    apb(1'b0, `SVRG_STATUS_OFS, 32'h0);
    chk("index", rd[27:20], 8'h08);
    chk("acc", rd[15:0], 16'h0800);
    tick(31);
    apb(1'b0, `SVRG_STATUS_OFS, 32'h0);
    chk("wrap", {rd[27:16], rd[15:0]}, {8'h00, 4'h9, 16'h0000});
  endtask
  task t_duty;
    apb(1'b1, `SVRG_MODIDX_OFS, 32'h7fff);
    apb(1'b1, `SVRG_STEP_OFS, 32'h0);
    restart;
    tick(2);
    chk("dy", duty_y, 10'h000);
    chk("dx", duty_x >= 10'd883 && duty_x <= 10'd885, 1'b1);
    chk("dz", duty_z, 11'h400 - duty_x);
    apb(1'b1, `SVRG_MODIDX_OFS, 32'h8000);
    tick(2);
    chk("neg", {duty_z, duty_y, duty_x}, {11'h400, 20'h0});
  endtask
  task btn(input logic [11:0] st, input logic u, input logic d, input logic [11:0] ex);
    apb(1'b1, `SVRG_STEP_OFS, {20'h0, st});
    tick(1);
    speed_up_button <= u;
    speed_down_button <= d;
    tick(1);
    speed_up_button <= 1'b0;
    speed_down_button <= 1'b0;
    chk("setpoint", freq_setpoint, ex);
  endtask
  task t_loop;
    restart;
    base = reg_cnt;
    tick(3);
    chk("open loop", {closed_loop_enable_flag, reg_cnt == base}, 2'b01);
    tick(5);
    chk("closed loop", {closed_loop_enable_flag, reg_cnt > base}, 2'b11);
  endtask
  task t_capture;
    base = spd_cnt;
    tick(2);
    chk("no capture", spd_cnt, base);
    capture_event <= 1'b1;
    @(posedge pclk);
    capture_event <= 1'b0;
    apb(1'b0, `SVRG_SPEED_OFS, 32'h0);
    chk("pending", rd, 32'h1);
    tick(1);
    chk("one update", spd_cnt, base + 1);
    tick(1);
    chk("consumed", spd_cnt, base + 1);
  endtask
  // ============================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_accum;
    t_duty;
    btn(12'h100, 1'b1, 1'b0, 12'h101);
    btn(12'h101, 1'b0, 1'b1, 12'h100);
    btn(12'h100, 1'b1, 1'b1, 12'h100);
    btn(12'h800, 1'b1, 1'b0, 12'h800);
    btn(12'h000, 1'b0, 1'b1, 12'h000);
    t_loop;
    t_capture;
    conclude;
  end
  initial begin
    #6000000;
    fail_count = fail_count + 1;
    conclude;
  end
endmodule
bind svrg_core svrg_core_chk #(.STARTUP_TICKS(STARTUP_TICKS)) u_svrg_core_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .period_event(period_event), .speed_up_button(speed_up_button),
  .speed_down_button(speed_down_button), .duty_x(duty_x), .duty_y(duty_y), .duty_z(duty_z), .sector(sector),
  .duty_valid(duty_valid), .closed_loop_enable_flag(closed_loop_enable_flag), .regulate_strobe(regulate_strobe),
  .speed_update_strobe(speed_update_strobe), .freq_setpoint(freq_setpoint));

// >>> svrg_map.vh
// Constants of the space vector reference generator: register map,
// field positions, reset values, limits and timing counts.
// Assumes it is included by bare name into the design modules.
`ifndef SVRG_MAP_VH
`define SVRG_MAP_VH

// ============================================================
// Register byte offsets (APB, one aligned word each)
`define SVRG_CTRL_OFS 8'h00
`define SVRG_STEP_OFS 8'h04
`define SVRG_MODIDX_OFS 8'h08
`define SVRG_STATUS_OFS 8'h0c
`define SVRG_DUTY_OFS 8'h10
`define SVRG_SPEED_OFS 8'h14

// ============================================================
// Field positions
`define SVRG_CTRL_RESTART_BIT 0
`define SVRG_STAT_SECTOR_LSB 16
`define SVRG_STAT_FLAG_BIT 19
`define SVRG_STAT_INDEX_LSB 20
`define SVRG_DUTY_Y_LSB 10
`define SVRG_DUTY_Z_LSB 20

// ============================================================
// Widths, limits and reset values
`define SVRG_ACC_W 16
`define SVRG_IDX_W 8
`define SVRG_STEP_W 12
`define SVRG_STEP_MAX 12'h800
`define SVRG_STEP_RST 12'h000
`define SVRG_MODIDX_RST 16'h0000
`define SVRG_SECTOR_LAST 3'h5
`define SVRG_IDX_LAST 8'hff
`define SVRG_DUTY_W 10
`define SVRG_FULL_PERIOD 11'h400
`define SVRG_ZERO_LO 3'h0
`define SVRG_ZERO_HI 3'h7

// ============================================================
// Timing: update period and open-loop startup interval
`define SVRG_PERIOD_NS 41600
`define SVRG_CLK_NS 100
`define SVRG_PERIOD_CYC (`SVRG_PERIOD_NS / `SVRG_CLK_NS)
`define SVRG_STARTUP_MS 1000
`define SVRG_STARTUP_TICKS ((`SVRG_STARTUP_MS * 1000000) / `SVRG_PERIOD_NS)

`endif

// >>> svrg_pwm_model.sv
// Model of the PWM timer side: issues the period tick.
// Assumes pclk at 10 MHz; ticks start after reset release.
`timescale 1ns/1ps
`include "svrg_map.vh"
module svrg_pwm_model #(
  parameter PERIOD = `SVRG_PERIOD_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Period tick towards the block
  output reg period_event
);
  reg [15:0] cnt_r;
  // ============================================================
  // Free-running period counter, one-cycle tick at its end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      period_event <= 1'b0;
    end else begin
      period_event <= (cnt_r == PERIOD - 1);
      cnt_r <= (cnt_r == PERIOD - 1) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end
endmodule

// >>> svrg_sine_rom.v
// Sine table over 60 electrical degrees, signed Q15, two read ports.
// Assumes the addresses are held by a clocked caller; data is registered.
`timescale 1ns/1ps
module svrg_sine_rom #(
  parameter DEPTH = 256,
  parameter AW = 8
) (
  // Clock
  input wire pclk,
  // Read ports
  input wire [AW-1:0] addr_a,
  input wire [AW-1:0] addr_b,
  output reg signed [15:0] data_a,
  output reg signed [15:0] data_b
);

  // ============================================================
  // Table build
  reg signed [15:0] table_mem [0:DEPTH-1];
  integer i;

  // Taylor series to x^7 in Q30; error stays well under one Q15 step up to 60 degrees
  function signed [15:0] svrg_sin;
    input integer idx;
    reg signed [63:0] x;
    reg signed [63:0] x2;
    reg signed [63:0] s;
    begin
      x = (64'sd4392268 * idx * 256) / DEPTH;
      x2 = (x * x) >>> 30;
      s = 64'sd1073741824 - ((x2 * 64'sd1073741824 / 64'sd42) >>> 30);
      s = 64'sd1073741824 - ((((x2 * s) >>> 30) * 64'sd1073741824 / 64'sd20) >>> 30);
      s = 64'sd1073741824 - ((((x2 * s) >>> 30) * 64'sd1073741824 / 64'sd6) >>> 30);
      s = (x * s) >>> 30;
      svrg_sin = s[30:15];
    end
  endfunction

  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      table_mem[i] = svrg_sin(i);
    end
  end

  // ============================================================
  // Registered reads
  always @(posedge pclk) begin
    data_a <= table_mem[addr_a];
    data_b <= table_mem[addr_b];
  end

endmodule
